// ==== inc/hot_swap_pkg.sv ====
package hot_swap_pkg;

  // Register offsets, byte addresses in configuration space
  localparam logic [7:0] HS_CTRL_OFFSET = 8'h74;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h80;
  localparam logic [7:0] IRQ_ENABLE_OFFSET = 8'h84;
  localparam logic [7:0] IRQ_CLEAR_OFFSET = 8'h88;

  // Field positions of the hot-swap control and status register
  localparam int CAP_ID_LSB = 0;
  localparam int NEXT_PTR_LSB = 8;
  localparam int HIDE_ARM_BIT = 16;
  localparam int EVENT_MASK_BIT = 17;
  localparam int PENDING_BIT = 18;
  localparam int LED_BIT = 19;
  localparam int LEVEL_LSB = 20;
  localparam int REMOVAL_BIT = 22;
  localparam int ADDED_BIT = 23;

  // Fixed field values
  localparam logic [7:0] CAP_ID_ENABLED = 8'h06;
  localparam logic [7:0] CAP_ID_DISABLED = 8'h00;
  localparam logic [7:0] NEXT_PTR_VALUE = 8'h00;
  localparam logic [1:0] INTERFACE_LEVEL_CODE = 2'h1;

  // Reset values of the writable and status fields
  localparam logic HIDE_ARM_RESET = 1'b0;
  localparam logic EVENT_MASK_RESET = 1'b0;
  localparam logic PENDING_ARM_RESET = 1'b0;
  localparam logic LED_RESET = 1'b0;
  localparam logic REMOVAL_FLAG_RESET = 1'b0;
  localparam logic BOARD_ADDED_FLAG_RESET = 1'b1;
  localparam logic [1:0] IRQ_STATUS_RESET = 2'h0;
  localparam logic [1:0] IRQ_ENABLE_RESET = 2'h0;

  // Interrupt status bit positions
  localparam int IRQ_ADDED_BIT = 0;
  localparam int IRQ_REMOVAL_BIT = 1;

  // Strap capture sequence, one-hot
  typedef enum logic [1:0] {
    STRAP_WAIT = 2'h1,
    STRAP_HELD = 2'h2
  } strap_state_type;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } cfg_req_type;

  // Board event inputs from the slot hardware
  typedef struct packed {
    logic inserted;
    logic removing;
  } board_evt_type;

endpackage : hot_swap_pkg

// ==== hw/hot_swap_capability_register.sv ====
module hot_swap_capability_register (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // Strap and slot events
  input wire logic hotswap_strap_enable_in,
  input wire hot_swap_pkg::board_evt_type board_evt_in,
  // Register port
  input wire hot_swap_pkg::cfg_req_type cfg_req_in,
  output logic [31:0] rd_data_out,
  // Slot and system outputs
  output logic board_event_n_out,
  output logic led_out,
  output logic hide_arm_out,
  output logic irq_out
);

  // Strap capture state
  hot_swap_pkg::strap_state_type strap_state_reg;
  hot_swap_pkg::strap_state_type strap_state_next;
  logic strap_reg;
  logic strap_next;

  // Control fields
  logic hide_arm_reg;
  logic hide_arm_next;
  logic event_mask_reg;
  logic event_mask_next;
  logic pending_arm_reg;
  logic pending_arm_next;
  logic led_reg;
  logic led_next;

  // Status flags
  logic removal_flag_reg;
  logic removal_flag_next;
  logic board_added_flag_reg;
  logic board_added_flag_next;

  // Interrupt state
  logic [1:0] irq_status_reg;
  logic [1:0] irq_status_next;
  logic [1:0] irq_enable_reg;
  logic [1:0] irq_enable_next;
  logic irq_reg;
  logic irq_next;

  // Output registers
  logic board_event_n_reg;
  logic board_event_n_next;
  logic [31:0] rd_data_reg;
  logic [31:0] rd_data_next;

  // Decoded accesses
  logic hs_wr;
  logic irq_enable_wr;
  logic irq_clear_wr;
  logic [31:0] hs_value;

  // Address decoding
  always_comb
  begin
    hs_wr = 1'b0;
    irq_enable_wr = 1'b0;
    irq_clear_wr = 1'b0;
    if (cfg_req_in.wr && cfg_req_in.addr == hot_swap_pkg::HS_CTRL_OFFSET)
    begin
      hs_wr = 1'b1;
    end
    else if (cfg_req_in.wr && cfg_req_in.addr == hot_swap_pkg::IRQ_ENABLE_OFFSET)
    begin
      irq_enable_wr = 1'b1;
    end
    else if (cfg_req_in.wr && cfg_req_in.addr == hot_swap_pkg::IRQ_CLEAR_OFFSET)
    begin
      irq_clear_wr = 1'b1;
    end
  end

  // Strap is caught once after reset release, so a later change
  // of the strap cannot move the capability ID under software
  always_comb
  begin
    strap_state_next = strap_state_reg;
    strap_next = strap_reg;
    case (strap_state_reg)
      hot_swap_pkg::STRAP_WAIT:
      begin
        strap_next = hotswap_strap_enable_in;
        strap_state_next = hot_swap_pkg::STRAP_HELD;
      end
      hot_swap_pkg::STRAP_HELD:
      begin
        strap_state_next = hot_swap_pkg::STRAP_HELD;
      end
      default:
      begin
        strap_state_next = hot_swap_pkg::STRAP_WAIT;
      end
    endcase
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      strap_state_reg <= hot_swap_pkg::STRAP_WAIT;
      strap_reg <= 1'b0;
    end
    else
    begin
      strap_state_reg <= strap_state_next;
      strap_reg <= strap_next;
    end
  end

  // Writable control fields of the hot-swap register
  always_comb
  begin
    hide_arm_next = hide_arm_reg;
    event_mask_next = event_mask_reg;
    pending_arm_next = pending_arm_reg;
    led_next = led_reg;
    if (hs_wr)
    begin
      hide_arm_next = cfg_req_in.wdata[hot_swap_pkg::HIDE_ARM_BIT];
      event_mask_next = cfg_req_in.wdata[hot_swap_pkg::EVENT_MASK_BIT];
      pending_arm_next = cfg_req_in.wdata[hot_swap_pkg::PENDING_BIT];
      led_next = cfg_req_in.wdata[hot_swap_pkg::LED_BIT];
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      hide_arm_reg <= hot_swap_pkg::HIDE_ARM_RESET;
      event_mask_reg <= hot_swap_pkg::EVENT_MASK_RESET;
      pending_arm_reg <= hot_swap_pkg::PENDING_ARM_RESET;
      led_reg <= hot_swap_pkg::LED_RESET;
    end
    else
    begin
      hide_arm_reg <= hide_arm_next;
      event_mask_reg <= event_mask_next;
      pending_arm_reg <= pending_arm_next;
      led_reg <= led_next;
    end
  end

  // Status flags: write one clears, a slot event in the same
  // cycle wins so that no insertion or extraction is lost
  always_comb
  begin
    removal_flag_next = removal_flag_reg;
    board_added_flag_next = board_added_flag_reg;
    if (hs_wr && cfg_req_in.wdata[hot_swap_pkg::REMOVAL_BIT])
    begin
      removal_flag_next = 1'b0;
    end
    if (hs_wr && cfg_req_in.wdata[hot_swap_pkg::ADDED_BIT])
    begin
      board_added_flag_next = 1'b0;
    end
    if (board_evt_in.removing)
    begin
      removal_flag_next = 1'b1;
    end
    if (board_evt_in.inserted)
    begin
      board_added_flag_next = 1'b1;
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      removal_flag_reg <= hot_swap_pkg::REMOVAL_FLAG_RESET;
      board_added_flag_reg <= hot_swap_pkg::BOARD_ADDED_FLAG_RESET;
    end
    else
    begin
      removal_flag_reg <= removal_flag_next;
      board_added_flag_reg <= board_added_flag_next;
    end
  end

  // Interrupt status is set by slot events; set wins over clear
  always_comb
  begin
    irq_status_next = irq_status_reg;
    irq_enable_next = irq_enable_reg;
    if (irq_clear_wr)
    begin
      irq_status_next = irq_status_reg & ~cfg_req_in.wdata[1:0];
    end
    if (board_evt_in.inserted)
    begin
      irq_status_next[hot_swap_pkg::IRQ_ADDED_BIT] = 1'b1;
    end
    if (board_evt_in.removing)
    begin
      irq_status_next[hot_swap_pkg::IRQ_REMOVAL_BIT] = 1'b1;
    end
    if (irq_enable_wr)
    begin
      irq_enable_next = cfg_req_in.wdata[1:0];
    end
    irq_next = |(irq_status_next & irq_enable_next);
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      irq_status_reg <= hot_swap_pkg::IRQ_STATUS_RESET;
      irq_enable_reg <= hot_swap_pkg::IRQ_ENABLE_RESET;
      irq_reg <= 1'b0;
    end
    else
    begin
      irq_status_reg <= irq_status_next;
      irq_enable_reg <= irq_enable_next;
      irq_reg <= irq_next;
    end
  end

  // Image of the hot-swap register as software reads it
  always_comb
  begin
    hs_value = 32'h0000_0000;
    if (strap_reg)
    begin
      hs_value[hot_swap_pkg::CAP_ID_LSB +: 8] = hot_swap_pkg::CAP_ID_ENABLED;
    end
    else
    begin
      hs_value[hot_swap_pkg::CAP_ID_LSB +: 8] = hot_swap_pkg::CAP_ID_DISABLED;
    end
    hs_value[hot_swap_pkg::NEXT_PTR_LSB +: 8] = hot_swap_pkg::NEXT_PTR_VALUE;
    hs_value[hot_swap_pkg::HIDE_ARM_BIT] = hide_arm_reg;
    hs_value[hot_swap_pkg::EVENT_MASK_BIT] = event_mask_reg;
    hs_value[hot_swap_pkg::PENDING_BIT] = pending_arm_reg | board_added_flag_reg | removal_flag_reg;
    hs_value[hot_swap_pkg::LED_BIT] = led_reg;
    hs_value[hot_swap_pkg::LEVEL_LSB +: 2] = hot_swap_pkg::INTERFACE_LEVEL_CODE;
    hs_value[hot_swap_pkg::REMOVAL_BIT] = removal_flag_reg;
    hs_value[hot_swap_pkg::ADDED_BIT] = board_added_flag_reg;
  end

  // Read data and slot outputs; the event line follows the flags
  // one cycle late because every output leaves from a flip-flop
  always_comb
  begin
    rd_data_next = 32'h0000_0000;
    if (cfg_req_in.rd && cfg_req_in.addr == hot_swap_pkg::HS_CTRL_OFFSET)
    begin
      rd_data_next = hs_value;
    end
    else if (cfg_req_in.rd && cfg_req_in.addr == hot_swap_pkg::IRQ_STATUS_OFFSET)
    begin
      rd_data_next = {30'h0000_0000, irq_status_reg};
    end
    else if (cfg_req_in.rd && cfg_req_in.addr == hot_swap_pkg::IRQ_ENABLE_OFFSET)
    begin
      rd_data_next = {30'h0000_0000, irq_enable_reg};
    end
    board_event_n_next = ~((board_added_flag_reg | removal_flag_reg) & ~event_mask_reg);
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      rd_data_reg <= 32'h0000_0000;
      board_event_n_reg <= 1'b0; // Added flag resets set, so the line starts asserted
    end
    else
    begin
      rd_data_reg <= rd_data_next;
      board_event_n_reg <= board_event_n_next;
    end
  end

  // Ports
  assign rd_data_out = rd_data_reg;
  assign board_event_n_out = board_event_n_reg;
  assign led_out = led_reg;
  assign hide_arm_out = hide_arm_reg;
  assign irq_out = irq_reg;

endmodule : hot_swap_capability_register

// ==== dv/hot_swap_properties.sv ====
// Watches the register port and slot outputs of the hot-swap register
module hot_swap_props (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // Observed inputs
  input wire logic hotswap_strap_enable_in,
  input wire hot_swap_pkg::board_evt_type board_evt_in,
  input wire hot_swap_pkg::cfg_req_type cfg_req_in,
  // Observed outputs
  input wire logic [31:0] rd_data_out,
  input wire logic board_event_n_out,
  input wire logic led_out,
  input wire logic hide_arm_out,
  input wire logic irq_out
);
  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (sys_rst_in);

  // Control register was read in the previous cycle
  sequence ctl_rd;
    $past(cfg_req_in.rd) && $past(cfg_req_in.addr) == hot_swap_pkg::HS_CTRL_OFFSET;
  endsequence

  // Fixed fields and the pending bit of a read; strap only changes under reset
  cap_id_a: assert property (ctl_rd |-> rd_data_out[7:0] == (hotswap_strap_enable_in ? 8'h06 : 8'h00))
    else $error("capability id wrong");
  next_ptr_a: assert property (ctl_rd |-> rd_data_out[15:8] == 8'h00)
    else $error("next pointer not zero");
  level_code_a: assert property (ctl_rd |-> rd_data_out[21:20] == 2'h1)
    else $error("interface level wrong");
  pend_flag_a: assert property ((ctl_rd and (rd_data_out[23:22] != 2'h0)) |-> rd_data_out[18])
    else $error("pending bit low with flag set");
  rsvd_zero_a: assert property ($past(cfg_req_in.rd) |-> rd_data_out[31:24] == 8'h00)
    else $error("reserved bits not zero");
  // The LED follows a control write on the next edge
  led_write_a: assert property ($past(cfg_req_in.wr) && $past(cfg_req_in.addr) == 8'h74
    |-> led_out == $past(cfg_req_in.wdata[19]))
    else $error("led does not follow write");
  // Both the read data and the event line lag the flags by one register
  evt_level_a: assert property (ctl_rd |-> board_event_n_out == !((|rd_data_out[23:22]) && !rd_data_out[17]))
    else $error("board event level wrong");
  rem_set_a: assert property (board_evt_in.removing ##1 (cfg_req_in.rd && cfg_req_in.addr == 8'h74)
    |=> rd_data_out[22] && rd_data_out[18])
    else $error("removal flag not set");

  // Main scenarios
  removal_c: cover property (board_evt_in.removing);
  event_c: cover property (!board_event_n_out ##1 board_event_n_out);
  irq_c: cover property (irq_out);
endmodule : hot_swap_props

bind hot_swap_capability_register hot_swap_props u_props (
  .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .hotswap_strap_enable_in(hotswap_strap_enable_in),
  .board_evt_in(board_evt_in), .cfg_req_in(cfg_req_in), .rd_data_out(rd_data_out),
  .board_event_n_out(board_event_n_out), .led_out(led_out), .hide_arm_out(hide_arm_out), .irq_out(irq_out));

// ==== dv/hot_swap_capability_register_test.sv ====
module hot_swap_capability_register_test;
  timeunit 1ns;
  timeprecision 100ps;

  `define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value at %0t: got %h exp %h", $time, g, e); end end

  // Stimulus, outputs and model state
  logic mclk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic strap = 1'b1;
  hot_swap_pkg::cfg_req_type req = '0;
  hot_swap_pkg::board_evt_type evt = '0;
  logic [31:0] rd_data;
  logic ev_n, led, hide, irq;
  int miscompares = 0;
  int n_compared = 0;
  bit add, rem, msk, ld, hd, arm;
  bit [1:0] en, st;
  logic [7:0] adr [5] = '{8'h74, 8'h80, 8'h84, 8'h88, 8'h90};
  logic [7:0] a;

  hot_swap_capability_register dut (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .hotswap_strap_enable_in(strap), .board_evt_in(evt),
    .cfg_req_in(req), .rd_data_out(rd_data), .board_event_n_out(ev_n), .led_out(led),
    .hide_arm_out(hide), .irq_out(irq));

  // 40 MHz clock
  always #12.5 mclk_in = ~mclk_in;

  // Expected read value; unmapped and write-only places read zero
  function automatic logic [31:0] exp_of(input logic [7:0] a);
    case (a)
      8'h74: return {8'h00, add, rem, 2'h1, ld, arm | add | rem, msk, hd, 8'h00, strap ? 8'h06 : 8'h00};
      8'h80: return {30'h0, st};
      8'h84: return {30'h0, en};
      default: return 32'h0;
    endcase
  endfunction : exp_of

  // One strobe cycle, then idle; ends just after the answer edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk_in);
    req <= '{addr: a, wdata: v, wr: w, rd: !w};
    @(posedge mclk_in);
    req <= '0;
    #1;
  endtask : bus

  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
    `CHK(rd_data, exp_of(a))
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bus(1'b1, a, v);
    if (a == 8'h74)
    begin
      hd = v[16];
      msk = v[17];
      arm = v[18];
      ld = v[19];
      rem &= !v[22];
      add &= !v[23];
    end
    if (a == 8'h84)
      en = v[1:0];
    if (a == 8'h88)
      st &= ~v[1:0];
  endtask : wr

  // Slot event pulse with a control read at the very next edge
  task automatic ev(input bit i, input bit r);
    @(posedge mclk_in);
    evt <= '{inserted: i, removing: r};
    @(posedge mclk_in);
    evt <= '0;
    req <= '{addr: 8'h74, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    add |= i;
    rem |= r;
    st |= {r, i};
    @(posedge mclk_in);
    req <= '0;
    #1;
    `CHK(rd_data, exp_of(8'h74))
  endtask : ev

  // Level outputs once the registered paths have settled
  task automatic outs();
    repeat (2) @(posedge mclk_in);
    #1;
    `CHK(ev_n, !((add | rem) & !msk))
    `CHK(led, ld)
    `CHK(hide, hd)
    `CHK(irq, |(st & en))
  endtask : outs

  task automatic reset(input bit s);
    @(posedge mclk_in);
    sys_rst_in <= 1'b1;
    strap <= s;
    repeat (10) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    {add, rem, msk, ld, hd, arm, en, st} = 10'h200;
    @(posedge mclk_in);
  endtask : reset

  task automatic give_verdict();
    $display("compared %0d, wrong %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  // Main sequence
  initial
  begin
    void'($urandom(32'hdd23));
    reset(1'b1);
    rd(8'h74);
    outs();
    $display("reset test done");
    // Random events, writes and reads over every mapped place and one hole
    repeat (40)
    begin
      ev(1'($urandom), 1'($urandom));
      wr(adr[$urandom_range(4)], $urandom);
      a = adr[$urandom_range(4)];
      rd(a);
      outs();
    end
    $display("random test done");
    // Strap low across a fresh reset
    reset(1'b0);
    rd(8'h74);
    $display("strap test done");
    give_verdict();
  end

  // Watchdog
  initial
  begin
    repeat (5000) @(posedge mclk_in);
    miscompares++;
    give_verdict();
  end
endmodule : hot_swap_capability_register_test
